//--- rtl/esp_pkg.sv
// Purpose: Shared constants and types for the enhanced serial port.
// Assumes: Single core clock; all port inputs synchronous to it.
// Notes: Mode codes follow the classic two-bit mode field.
package esp_pkg;

  localparam logic [1:0] ESP_MODE_SHIFT = 2'h0;
  localparam logic [1:0] ESP_MODE_UART8 = 2'h1;
  localparam logic [1:0] ESP_MODE_UART9 = 2'h2;
  localparam logic [1:0] ESP_MODE_FIXED = 2'h3;

  localparam logic [1:0] ESP_BAUD_TIMER1 = 2'h0;
  localparam logic [1:0] ESP_BAUD_BRG = 2'h1;

  localparam int ESP_SHIFT_DIV = 16;
  localparam int ESP_FIXED_DIV_SLOW = 32;
  localparam int ESP_FIXED_DIV_FAST = 16;
  localparam int ESP_OVS = 16;
  localparam int ESP_DATA_BITS = 8;
  localparam int ESP_FRAME8 = 10;
  localparam int ESP_FRAME9 = 11;
  localparam logic [3:0] ESP_OVS_MID = 4'h7;
  localparam logic [3:0] ESP_OVS_LAST = 4'hF;
  localparam logic [5:0] ESP_DIV_ZERO = 6'h00;
  localparam logic [3:0] ESP_BIT_ZERO = 4'h0;

  typedef struct packed {
    logic [1:0] mode;
    logic baud_sel;
    logic fixed_fast;
    logic rx_en;
    logic addr_en;
    logic tx_ninth_bit_flag;
    logic dbl_buf;
  } esp_ctrl_s;

  typedef struct packed {
    logic tx_done;
    logic rx_done;
    logic framing_err;
    logic overrun;
    logic rx_ninth_bit_flag;
  } esp_stat_s;

  typedef enum logic [2:0] {
    ESP_TX_IDLE = 3'b001,
    ESP_TX_SEND = 3'b010,
    ESP_TX_SHIFT = 3'b100
  } esp_tx_e;

  typedef enum logic [2:0] {
    ESP_RX_IDLE = 3'b001,
    ESP_RX_RECV = 3'b010,
    ESP_RX_SHIFT = 3'b100
  } esp_rx_e;

endpackage : esp_pkg

//--- rtl/esp_serial_port.sv
// Purpose: Enhanced serial port, four modes, selectable baud source.
// Assumes: Baud ticks from timer 1 and the generator are 16x strobes.
// Notes: Control arrives as plain ports; flags clear by pulse inputs.
`timescale 1ns/1ps

// Behaviour
// - Four modes: shift, 8-bit, 9-bit, fixed
// - Baud from fixed divider, timer1, generator
// - No timer 2 baud source offered
// - Framing error, address match on rx_sr_q[9:2] (the data byte in 8-bit mode), double buffer, interrupts
// - Shift mode: data on rxd, clock on txd
// - Shift mode moves eight bits, LSB first
// - Shift mode rate is core clock over 16
// - 8-bit frame: start, eight data, stop
// - 8-bit receive stores stop bit as ninth
// - 8-bit mode rate from timer1 or generator
// - 9-bit frame: start, eight, ninth, stop
// - Transmitted ninth bit from control flag
module esp_serial_port
  import esp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control and baud ticks
  input wire esp_pkg::esp_ctrl_s ctrl,
  input wire logic [DATA_W-1:0] own_addr,
  input wire logic [DATA_W-1:0] addr_mask,
  input wire logic t1_ovf,
  input wire logic brg_tick,
  // Transmit request
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  output logic tx_ready,
  // Receive data and flag clears
  output logic [DATA_W-1:0] rx_data,
  input wire logic clr_tx_done,
  input wire logic clr_rx_done,
  input wire logic clr_err,
  output esp_pkg::esp_stat_s stat,
  output logic irq,
  // Pins
  output logic txd,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe
);
  import esp_pkg::*;

  localparam logic [5:0] DIV_SHIFT = 6'(ESP_SHIFT_DIV - 1);
  localparam logic [5:0] DIV_SLOW = 6'(ESP_FIXED_DIV_SLOW / ESP_OVS - 1);
  localparam logic [5:0] DIV_FAST = 6'(ESP_FIXED_DIV_FAST / ESP_OVS - 1);
  localparam logic [3:0] LAST8 = 4'(ESP_FRAME8 - 1);
  localparam logic [3:0] LAST9 = 4'(ESP_FRAME9 - 1);
  localparam logic [3:0] LAST_SH = 4'(ESP_DATA_BITS - 1);
  localparam logic [3:0] HALF_SH = 4'(ESP_SHIFT_DIV / 2 - 1);

  logic is_shift;
  logic is_nine;
  logic ovs_tick;
  logic [5:0] div_q;
  logic [3:0] sh_ph_q;
  logic sh_tick;
  logic [3:0] last_bit;

  assign is_shift = (ctrl.mode == ESP_MODE_SHIFT);
  assign is_nine = ctrl.mode[1];
  assign last_bit = is_nine ? LAST9 : LAST8;

  // Fixed divider for modes 2 and 3 fast/slow; timer 2 is never wired in
  always_ff @(posedge core_clk) begin
    if (!rstn || div_q == ESP_DIV_ZERO) begin
      div_q <= ctrl.fixed_fast ? DIV_FAST : DIV_SLOW;
    end else begin
      div_q <= div_q - 6'h01;
    end
  end

  // Oversample tick source by mode
  always_comb begin
    unique case (ctrl.mode)
      ESP_MODE_UART8: ovs_tick = ctrl.baud_sel ? brg_tick : t1_ovf;
      ESP_MODE_UART9: ovs_tick = (div_q == ESP_DIV_ZERO);
      ESP_MODE_FIXED: ovs_tick = (div_q == ESP_DIV_ZERO);
      default: ovs_tick = 1'b0;
    endcase
  end

  // Shift mode phase counter: one bit per 16 core clocks
  always_ff @(posedge core_clk) begin
    if (!rstn || !is_shift) begin
      sh_ph_q <= ESP_BIT_ZERO;
    end else begin
      sh_ph_q <= sh_ph_q + 4'h1;
    end
  end
  assign sh_tick = is_shift && (sh_ph_q == DIV_SHIFT[3:0]);

  // Transmitter
  esp_tx_e tx_st_q;
  logic [10:0] tx_sr_q;
  logic [3:0] tx_bit_q;
  logic [3:0] tx_ovs_q;
  logic [DATA_W-1:0] tx_hold_q;
  logic tx_hold_v_q;
  logic tx_end;
  logic tx_load;

  assign tx_ready = !tx_hold_v_q && (ctrl.dbl_buf || tx_st_q == ESP_TX_IDLE);
  // Shift mode starts on a phase wrap so the first clock low is full length
  assign tx_load = tx_st_q == ESP_TX_IDLE && tx_hold_v_q &&
                   (!is_shift || sh_tick);
  assign tx_end = (tx_st_q == ESP_TX_SEND && ovs_tick &&
                   tx_ovs_q == ESP_OVS_LAST && tx_bit_q == last_bit) ||
                  (tx_st_q == ESP_TX_SHIFT && sh_tick && tx_bit_q == LAST_SH);

  // Holding register gives double buffering when enabled
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_hold_v_q <= 1'b0;
      tx_hold_q <= '0;
    end else if (tx_valid && tx_ready) begin
      tx_hold_v_q <= 1'b1;
      tx_hold_q <= tx_data;
    end else if (tx_load) begin
      tx_hold_v_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_st_q <= ESP_TX_IDLE;
      tx_sr_q <= '1;
      tx_bit_q <= ESP_BIT_ZERO;
      tx_ovs_q <= 4'h0;
    end else begin
      unique case (tx_st_q)
        ESP_TX_IDLE: begin
          if (tx_load && is_shift) begin
            tx_sr_q <= {3'h7, tx_hold_q};
            tx_bit_q <= ESP_BIT_ZERO;
            tx_st_q <= ESP_TX_SHIFT;
          end else if (tx_load) begin
            // Stop, ninth (or stop again), data LSB first, start low
            tx_sr_q <= {1'b1, is_nine ? ctrl.tx_ninth_bit_flag : 1'b1,
                        tx_hold_q, 1'b0};
            tx_bit_q <= ESP_BIT_ZERO;
            tx_ovs_q <= 4'h0;
            tx_st_q <= ESP_TX_SEND;
          end
        end
        ESP_TX_SEND: begin
          if (ovs_tick) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == ESP_OVS_LAST) begin
              tx_sr_q <= {1'b1, tx_sr_q[10:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_end) tx_st_q <= ESP_TX_IDLE;
            end
          end
        end
        ESP_TX_SHIFT: begin
          if (sh_tick) begin
            tx_sr_q <= {1'b1, tx_sr_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_end) tx_st_q <= ESP_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receiver
  esp_rx_e rx_st_q;
  logic [9:0] rx_sr_q;
  logic [3:0] rx_bit_q;
  logic [3:0] rx_ovs_q;
  logic rx_end;
  logic rx_stop;
  logic rx_ninth;
  logic addr_hit;

  assign rx_stop = rxd_i;
  assign rx_ninth = is_nine ? rx_sr_q[9] : rx_stop;
  assign addr_hit = ((rx_sr_q[9:2] ^ own_addr) & addr_mask) == '0;

  // Shift-mode data pin is driven only while a transmit is under way
  assign rxd_oe = (tx_st_q == ESP_TX_SHIFT);
  assign rxd_o = tx_sr_q[0];
  assign txd = is_shift ? !(rx_st_q == ESP_RX_SHIFT || rxd_oe) ||
               (sh_ph_q > HALF_SH) : tx_sr_q[0];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_st_q <= ESP_RX_IDLE;
      rx_sr_q <= '0;
      rx_bit_q <= ESP_BIT_ZERO;
      rx_ovs_q <= 4'h0;
      rx_end <= 1'b0;
    end else begin
      rx_end <= 1'b0;
      unique case (rx_st_q)
        ESP_RX_IDLE: begin
          rx_bit_q <= ESP_BIT_ZERO;
          rx_ovs_q <= 4'h0;
          if (ctrl.rx_en && is_shift && !stat.rx_done && sh_tick) begin
            rx_st_q <= ESP_RX_SHIFT;
          end else if (ctrl.rx_en && !is_shift && !rxd_i) begin
            rx_st_q <= ESP_RX_RECV;
          end
        end
        ESP_RX_RECV: begin
          if (ovs_tick) begin
            rx_ovs_q <= rx_ovs_q + 4'h1;
            if (rx_ovs_q == ESP_OVS_MID) begin
              if (rx_bit_q == ESP_BIT_ZERO && rxd_i) begin
                rx_st_q <= ESP_RX_IDLE; // false start
              end else if (rx_bit_q == last_bit) begin
                rx_end <= 1'b1;
                rx_st_q <= ESP_RX_IDLE;
              end else begin
                if (rx_bit_q != ESP_BIT_ZERO) begin
                  rx_sr_q <= {rxd_i, rx_sr_q[9:1]};
                end
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end
          end
        end
        ESP_RX_SHIFT: begin
          if (sh_tick) begin
            rx_sr_q <= {rxd_i, rx_sr_q[9:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == LAST_SH) begin
              rx_end <= 1'b1;
              rx_st_q <= ESP_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Framing and character acceptance; the stop bit is sampled in the cycle before rx_end
  logic [DATA_W-1:0] rx_byte;
  logic rx_stop_q;
  logic accept;
  logic end_ok;
  always_ff @(posedge core_clk) begin
    if (!rstn) rx_stop_q <= 1'b1;
    else if (rx_st_q == ESP_RX_RECV && rx_bit_q == last_bit) rx_stop_q <= rxd_i;
  end
  assign rx_byte = is_shift ? rx_sr_q[9:2] : (is_nine ? rx_sr_q[8:1] :
                   rx_sr_q[9:2]);
  // Outside shift mode, address mode takes only frames whose ninth bit is set and whose rx_sr_q[9:2] matches
  assign end_ok = !ctrl.addr_en || is_shift ||
                  (rx_ninth && addr_hit);
  assign accept = rx_end && end_ok && (!stat.rx_done || ctrl.dbl_buf);

  // Flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stat <= '0;
      rx_data <= '0;
    end else begin
      if (tx_end) stat.tx_done <= 1'b1;
      else if (clr_tx_done) stat.tx_done <= 1'b0;
      if (accept) stat.rx_done <= 1'b1;
      else if (clr_rx_done) stat.rx_done <= 1'b0;
      if (rx_end && !is_shift && !rx_stop_q) stat.framing_err <= 1'b1;
      else if (clr_err) stat.framing_err <= 1'b0;
      if (rx_end && end_ok && stat.rx_done && !clr_rx_done) begin
        stat.overrun <= 1'b1;
      end else if (clr_err) begin
        stat.overrun <= 1'b0;
      end
      if (accept) begin
        rx_data <= rx_byte;
        stat.rx_ninth_bit_flag <= is_shift ? 1'b0 :
                                  (is_nine ? rx_sr_q[9] : rx_stop_q);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) irq <= 1'b0;
    else irq <= stat.tx_done || stat.rx_done;
  end

endmodule : esp_serial_port

//--- sim/esp_checker.sv
// Purpose: Port-level checks for the serial port.
// Assumes: Bench drives control steady through each frame.
// Notes: Bound to every instance of the port.
`timescale 1ns/1ps
module esp_checker
  import esp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watched ports
  input wire esp_pkg::esp_ctrl_s ctrl,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire esp_pkg::esp_stat_s stat,
  input wire logic clr_tx_done,
  input wire logic clr_rx_done,
  input wire logic irq,
  input wire logic txd,
  input wire logic rxd_oe
);
  import esp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_reset_idle: assert property (
    disable iff (1'h0) !rstn |=> txd && !rxd_oe && !irq && tx_ready
    && stat == 5'h00) else $error("outputs not idle in reset");
  a_start_low: assert property (
    tx_valid && tx_ready && ctrl.mode == ESP_MODE_UART8
    |-> ##[1:2] !txd [*8]) else $error("start bit missing");
  a_ready_busy: assert property (
    tx_valid && tx_ready && !ctrl.dbl_buf |=> !tx_ready)
    else $error("accepted while sending");
  a_oe_shift: assert property (
    rxd_oe |-> ctrl.mode == ESP_MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  a_shift_clk: assert property (
    ctrl.mode == ESP_MODE_SHIFT && $fell(txd) |-> !txd [*8] ##1 txd)
    else $error("shift clock low phase not 8 cycles");
  a_irq_follow: assert property (
    1'h1 |=> irq == $past(stat.tx_done || stat.rx_done))
    else $error("interrupt not following flags");
  a_txdone_hold: assert property (
    stat.tx_done && !clr_tx_done |=> stat.tx_done)
    else $error("transmit flag lost");
  a_rxdone_hold: assert property (
    stat.rx_done && !clr_rx_done |=> stat.rx_done)
    else $error("receive flag lost");
endmodule : esp_checker

bind esp_serial_port esp_checker u_chk (.core_clk(core_clk), .rstn(rstn),
  .ctrl(ctrl), .tx_valid(tx_valid), .tx_ready(tx_ready), .stat(stat),
  .clr_tx_done(clr_tx_done), .clr_rx_done(clr_rx_done), .irq(irq),
  .txd(txd), .rxd_oe(rxd_oe));

//--- sim/esp_far_end.sv
// Purpose: Remote transmitter feeding the receive pin.
// Assumes: Called at a rising edge of the core clock.
// Notes: Line idles high between frames.
`timescale 1ns/1ps
module esp_far_end (
  // Clock and line
  input wire logic core_clk,
  output logic line
);
  initial line = 1'h1;
  task automatic send(input logic [10:0] fr, input int per);
    for (int i = 0; i < 11; i++) begin
      line <= fr[i];
      repeat (per) @(posedge core_clk);
    end
    line <= 1'h1;
  endtask : send
endmodule : esp_far_end

//--- sim/esp_serial_port_tb.sv
// Purpose: Self-checking bench for the serial port.
// Assumes: Generator ticks every cycle, timer 1 every other.
// Notes: Address match is left off, so its inputs are tied.
`timescale 1ns/1ps
module esp_serial_port_tb;
  import esp_pkg::*;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
  int num_errors = 0;
  int n_checks = 0;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  esp_ctrl_s ctrl = 8'h00;
  logic t1_ovf = 1'h0;
  logic brg_tick = 1'h0;
  logic tx_valid = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic clr_tx_done = 1'h0;
  logic clr_rx_done = 1'h0;
  logic clr_err = 1'h0;
  logic tx_ready, irq, txd, rxd_i, rxd_o, rxd_oe;
  logic [7:0] rx_data;
  esp_stat_s stat;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    t1_ovf <= ~t1_ovf;
    brg_tick <= 1'h1;
  end
  esp_serial_port dut (.core_clk(core_clk), .rstn(rstn), .ctrl(ctrl),
    .own_addr(8'h00), .addr_mask(8'h00), .t1_ovf(t1_ovf),
    .brg_tick(brg_tick), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_data(rx_data), .clr_tx_done(clr_tx_done),
    .clr_rx_done(clr_rx_done), .clr_err(clr_err), .stat(stat), .irq(irq),
    .txd(txd), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe(rxd_oe));
  esp_far_end far (.core_clk(core_clk), .line(rxd_i));
  task automatic wt(input int k);
    repeat (k) @(negedge core_clk);
  endtask : wt
  task automatic report_and_stop;
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic send_byte(input logic [7:0] c, input logic [7:0] d);
    @(posedge core_clk);
    ctrl <= c;
    tx_data <= d;
    tx_valid <= 1'h1;
    wt(1);
    while (tx_ready !== 1'h1) wt(1);
    @(posedge core_clk);
    tx_valid <= 1'h0;
  endtask : send_byte
  // Flag must stand until cleared, and irq must drop with it
  task automatic clr_tx;
    `CHK("tx done", 1'h1, stat.tx_done)
    `CHK("irq", 1'h1, irq)
    @(posedge core_clk);
    clr_tx_done <= 1'h1;
    @(posedge core_clk);
    clr_tx_done <= 1'h0;
    wt(2);
    `CHK("tx done clear", 1'h0, stat.tx_done)
    `CHK("irq clear", 1'h0, irq)
  endtask : clr_tx
  task automatic t_reset;
    `CHK("txd idle", 1'h1, txd)
    `CHK("oe idle", 1'h0, rxd_oe)
    `CHK("stat idle", 5'h00, stat)
    `CHK("ready idle", 1'h1, tx_ready)
  endtask : t_reset
  task automatic t_tx(input logic [1:0] md, input logic bs, fs, nb,
                      input logic [7:0] d, input int per);
    logic [10:0] fr;
    int n;
    int i;
    fr = (md == ESP_MODE_UART8) ? {2'h3, d, 1'h0} : {1'h1, nb, d, 1'h0};
    n = (md == ESP_MODE_UART8) ? ESP_FRAME8 : ESP_FRAME9;
    send_byte({md, bs, fs, 1'h0, 1'h0, nb, 1'h0}, d);
    i = 0;
    while (txd !== 1'h0 && i < 80) begin
      wt(1);
      i++;
    end
    wt(per / 2);
    for (int b = 0; b < n; b++) begin
      `CHK("txd bit", fr[b], txd)
      wt(per);
    end
    clr_tx();
  endtask : t_tx
  task automatic t_rx(input logic [1:0] md, input logic fs, nb, stp,
                      input logic [7:0] d, input int per);
    int i;
    logic e9;
    e9 = (md == ESP_MODE_UART8) ? stp : nb;
    @(posedge core_clk);
    ctrl <= {md, 1'h1, fs, 1'h1, 1'h0, 1'h0, 1'h0};
    @(posedge core_clk);
    if (md == ESP_MODE_UART8) far.send({1'h1, stp, d, 1'h0}, per);
    else far.send({stp, nb, d, 1'h0}, per);
    i = 0;
    while (stat.rx_done !== 1'h1 && i < 64) begin
      wt(1);
      i++;
    end
    `CHK("rx data", d, rx_data)
    `CHK("rx ninth", e9, stat.rx_ninth_bit_flag)
    `CHK("framing", ~stp, stat.framing_err)
    `CHK("overrun", 1'h0, stat.overrun)
    // A low stop bit looks like a new start; let that frame run out first
    wt(per * 12);
    @(posedge core_clk);
    clr_rx_done <= 1'h1;
    clr_err <= 1'h1;
    @(posedge core_clk);
    clr_rx_done <= 1'h0;
    clr_err <= 1'h0;
    wt(2);
    `CHK("rx done clear", 1'h0, stat.rx_done)
  endtask : t_rx
  task automatic t_shift(input logic [7:0] d);
    int i;
    send_byte({ESP_MODE_SHIFT, 6'h00}, d);
    for (int b = 0; b < ESP_DATA_BITS; b++) begin
      i = 0;
      while (txd !== 1'h0 && i < 40) begin
        wt(1);
        i++;
      end
      `CHK("shift oe", 1'h1, rxd_oe)
      wt(ESP_SHIFT_DIV / 2);
      `CHK("shift clock", 1'h1, txd)
      `CHK("shift data", d[b], rxd_o)
    end
    wt(16);
    clr_tx();
  endtask : t_shift
  initial begin
    repeat (10000) @(posedge core_clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'h1;
    wt(1);
    t_reset();
    t_tx(ESP_MODE_UART8, 1'h1, 1'h0, 1'h1, 8'hA5, 16);
    t_tx(ESP_MODE_UART8, 1'h0, 1'h0, 1'h0, 8'h3C, 32);
    t_tx(ESP_MODE_UART9, 1'h0, 1'h1, 1'h1, 8'h81, 16);
    t_tx(ESP_MODE_UART9, 1'h0, 1'h0, 1'h0, 8'h7E, 32);
    t_rx(ESP_MODE_UART8, 1'h0, 1'h0, 1'h1, 8'hC3, 16);
    t_rx(ESP_MODE_UART8, 1'h0, 1'h0, 1'h0, 8'h5A, 16);
    t_rx(ESP_MODE_UART9, 1'h1, 1'h1, 1'h1, 8'h96, 16);
    t_rx(ESP_MODE_UART9, 1'h0, 1'h0, 1'h1, 8'h0F, 32);
    t_shift(8'hB4);
    report_and_stop();
  end
endmodule : esp_serial_port_tb
